//--- verilog/chg_pkg.sv
// Purpose: Shared constants for the charger control-pin logic
// Assumes: 100 MHz core clock
// Notes: Timer lengths in their own units, cycle counts derived here
`default_nettype none
package chg_pkg;
    localparam int CHG_CLK_MHZ = 100;
    localparam int CHG_FAULT_PULSE_US = 128;
    localparam int CHG_FAULT_PULSE_CYC = CHG_FAULT_PULSE_US * CHG_CLK_MHZ;
    localparam int CHG_T15_MIN = 15;
    localparam longint CHG_T15_CYC = longint'(CHG_T15_MIN) * 60 * 1000000 * CHG_CLK_MHZ;
    localparam int CHG_T32_SEC = 32;
    localparam longint CHG_T32_CYC = longint'(CHG_T32_SEC) * 1000000 * CHG_CLK_MHZ;
    localparam int CHG_TMR_W = 38;
    localparam int CHG_SL_W = 8;
    localparam logic [7:0] CHG_SL_RESET = 8'h00;
    localparam logic CHG_LIMIT_500 = 1'b1;
    localparam logic CHG_LIMIT_100 = 1'b0;
    typedef enum logic [1:0] {
        CHG_ST_IDLE = 2'b00,
        CHG_ST_CHARGE = 2'b01,
        CHG_ST_FAULT = 2'b10
    } chg_stat_e;
endpackage
`default_nettype wire

//--- verilog/chg_sync.sv
// Purpose: Two flip-flop synchroniser for a bus of pin levels
// Assumes: Single clock, active-low reset already synchronised
// Notes: First stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module chg_sync #(
    parameter int W = 3
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] q_reg;
    logic [W-1:0] q_next;

    always_comb begin
        meta_next = d;
        q_next = meta_reg;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            q_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            q_reg <= q_next;
        end
    end

    assign q = q_reg;
endmodule
`default_nettype wire

//--- verilog/chg_ctrl.sv
// Purpose: Status pin, charge disable, boost/limit select and safety-limit lock
// Assumes: Register writes arrive as one-cycle strobes from the serial decoder
// Notes: Fault pulse length and timer lengths are parameters for short simulation
//
// Summary of operation
// - Status pin is pulled low while charging and released otherwise.
// - A fault sends one low pulse of 128 us on the status pin.
// - Clearing the status enable bit silences the status pin completely.
// - Charge-disable high stops charging and puts the supply input in high impedance.
// - In fifteen-minute mode, charge-disable high restarts the safety timer.
// - In thirty-two-second mode, charge-disable high leaves the timer running.
// - Active boost/select pin configured as boost enable forces boost mode.
// - The pin is ORed with serial boost requests unless its boost function is disabled.
// - After reset the pin selects input limit, high for 500 mA and low for 100 mA.
// - Safety-limit reset pin low holds limits at defaults and ignores writes.
// - With that pin high, limits are writable until any other register write locks them.
// - A safety timer with host reset backs up serial supervision.
`timescale 1ns/1ps
`default_nettype none
module chg_ctrl
    import chg_pkg::*;
#(
    parameter int FAULT_CYC = CHG_FAULT_PULSE_CYC,
    parameter longint T15_CYC = CHG_T15_CYC,
    parameter longint T32_CYC = CHG_T32_CYC,
    parameter int SL_W = CHG_SL_W
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic charge_disable_input,
    input wire logic boost_or_limit_select_pin,
    input wire logic safety_limit_reset_pin,
    input wire logic charging_active,
    input wire logic fault_event,
    input wire logic stat_enable,
    input wire logic pin_boost_cfg,
    input wire logic pin_boost_disable,
    input wire logic i2c_boost_req,
    input wire logic timer_mode_15min,
    input wire logic timer_host_reset,
    input wire logic sl_write,
    input wire logic other_write,
    input wire logic [SL_W-1:0] sl_wdata,
    output logic stat_out,
    output logic stat_oe,
    output logic charge_enable,
    output logic vbus_hiz,
    output logic boost_mode,
    output logic input_limit_500,
    output logic [SL_W-1:0] safety_limits,
    output logic safety_locked,
    output logic timer_expired
);
    logic rst_s1_reg;
    logic rst_s1_next;
    logic rst_n_reg;
    logic rst_n_next;
    logic [2:0] pins_raw;
    logic [2:0] pins_s;
    logic dis_s;
    logic sel_s;
    logic slr_s;

    // Pin boost decode is shared by the boost and limit paths
    function automatic logic pin_boost_on(input logic cfg, input logic off);
        return cfg && !off;
    endfunction

    // Reset leaves through two flops so every register quits reset on one edge
    always_comb begin
        rst_s1_next = 1'b1;
        rst_n_next = rst_s1_reg;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_s1_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_s1_reg <= rst_s1_next;
            rst_n_reg <= rst_n_next;
        end
    end

    // Pin order: disable, select, limit reset
    assign pins_raw = {charge_disable_input, boost_or_limit_select_pin, safety_limit_reset_pin};

    chg_sync #(.W(3)) u_sync (
        .clk(clk),
        .rst_n(rst_n_reg),
        .d(pins_raw),
        .q(pins_s)
    );
    assign dis_s = pins_s[2];
    assign sel_s = pins_s[1];
    assign slr_s = pins_s[0];

    // Status pin state
    chg_stat_e st_reg;
    chg_stat_e st_next;
    // Counter is wide enough for the full-length pulse, not only a short test value
    logic [31:0] pcnt_reg;
    logic [31:0] pcnt_next;
    logic stat_oe_reg;
    logic stat_oe_next;
    logic stat_out_reg;
    logic stat_out_next;

    always_comb begin
        st_next = st_reg;
        pcnt_next = pcnt_reg;
        // Open-drain data level; only the enable moves
        stat_out_next = 1'b0;
        case (st_reg)
            CHG_ST_IDLE, CHG_ST_CHARGE: begin
                if (fault_event) begin
                    st_next = CHG_ST_FAULT;
                    pcnt_next = 32'(FAULT_CYC - 1);
                end else if (charging_active) begin
                    st_next = CHG_ST_CHARGE;
                end else begin
                    st_next = CHG_ST_IDLE;
                end
            end
            CHG_ST_FAULT: begin
                if (pcnt_reg == 32'h0) begin
                    st_next = charging_active ? CHG_ST_CHARGE : CHG_ST_IDLE;
                end else begin
                    pcnt_next = pcnt_reg - 32'h1;
                end
            end
            default: begin
                st_next = CHG_ST_IDLE;
            end
        endcase
        stat_oe_next = (st_next != CHG_ST_IDLE);
        if (!stat_enable) begin
            stat_oe_next = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            st_reg <= CHG_ST_IDLE;
            pcnt_reg <= 32'h0;
            stat_oe_reg <= 1'b0;
            stat_out_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            pcnt_reg <= pcnt_next;
            stat_oe_reg <= stat_oe_next;
            stat_out_reg <= stat_out_next;
        end
    end

    // Charge disable, boost and limit select
    logic chg_en_reg;
    logic chg_en_next;
    logic hiz_reg;
    logic hiz_next;
    logic boost_reg;
    logic boost_next;
    logic lim_reg;
    logic lim_next;

    always_comb begin
        chg_en_next = !dis_s;
        hiz_next = dis_s;
        if (pin_boost_on(pin_boost_cfg, pin_boost_disable)) begin
            boost_next = sel_s | i2c_boost_req;
        end else begin
            boost_next = i2c_boost_req;
        end
        // Limit is frozen while the pin acts as boost enable, so boost use cannot flip it
        // limit select level
        if (pin_boost_on(pin_boost_cfg, pin_boost_disable)) begin
            lim_next = lim_reg;
        end else begin
            lim_next = sel_s ? CHG_LIMIT_500 : CHG_LIMIT_100;
        end
    end

    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            chg_en_reg <= 1'b0;
            hiz_reg <= 1'b0;
            boost_reg <= 1'b0;
            lim_reg <= CHG_LIMIT_100;
        end else begin
            chg_en_reg <= chg_en_next;
            hiz_reg <= hiz_next;
            boost_reg <= boost_next;
            lim_reg <= lim_next;
        end
    end

    // Safety timer; wide counter since 15 min at 100 MHz needs 37 bits
    logic [CHG_TMR_W-1:0] tmr_reg;
    logic [CHG_TMR_W-1:0] tmr_next;
    logic exp_reg;
    logic exp_next;
    logic dis_d_reg;
    logic dis_d_next;
    logic dis_rise;
    logic [CHG_TMR_W-1:0] tmr_limit;

    // Edge memory resets to the idle pin level, so leaving reset is no restart
    assign dis_rise = dis_s && !dis_d_reg;
    assign tmr_limit = timer_mode_15min ? CHG_TMR_W'(T15_CYC - 1) : CHG_TMR_W'(T32_CYC - 1);

    always_comb begin
        tmr_next = tmr_reg;
        exp_next = exp_reg;
        dis_d_next = dis_s;
        // Counter parks at the limit; only a restart clears the sticky flag
        // host timer reset
        if (timer_host_reset) begin
            tmr_next = '0;
            exp_next = 1'b0;
        end else if (timer_mode_15min && dis_rise) begin
            tmr_next = '0;
            exp_next = 1'b0;
        end else if (tmr_reg >= tmr_limit) begin
            exp_next = 1'b1;
        end else begin
            tmr_next = tmr_reg + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            tmr_reg <= '0;
            exp_reg <= 1'b0;
            dis_d_reg <= 1'b0;
        end else begin
            tmr_reg <= tmr_next;
            exp_reg <= exp_next;
            dis_d_reg <= dis_d_next;
        end
    end

    // Safety-limit register and lock
    logic [SL_W-1:0] sl_reg;
    logic [SL_W-1:0] sl_next;
    // Lock clears only through the reset pin, so software cannot reopen the limits
    logic lock_reg;
    logic lock_next;

    always_comb begin
        sl_next = sl_reg;
        lock_next = lock_reg;
        if (!slr_s) begin
            sl_next = SL_W'(CHG_SL_RESET);
            lock_next = 1'b0;
        end else begin
            if (sl_write && !lock_reg) begin
                sl_next = sl_wdata;
            end
            if (other_write) begin
                lock_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            sl_reg <= SL_W'(CHG_SL_RESET);
            lock_reg <= 1'b0;
        end else begin
            sl_reg <= sl_next;
            lock_reg <= lock_next;
        end
    end

    assign stat_out = stat_out_reg;
    assign stat_oe = stat_oe_reg;
    assign charge_enable = chg_en_reg;
    assign vbus_hiz = hiz_reg;
    assign boost_mode = boost_reg;
    assign input_limit_500 = lim_reg;
    assign safety_limits = sl_reg;
    assign safety_locked = lock_reg;
    assign timer_expired = exp_reg;
endmodule
`default_nettype wire

//--- bench/chg_ctrl_properties.sv
// Purpose: Port checks for chg_ctrl
// Assumes: Short fault pulse parameter
// Notes: Checks wait out the reset and pin synchronisers
`timescale 1ns/1ps
`default_nettype none
module chg_ctrl_props
    import chg_pkg::*;
#(
    parameter int FAULT_CYC = 8,
    parameter int SL_W = 8
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic charge_disable_input,
    input wire logic boost_or_limit_select_pin,
    input wire logic safety_limit_reset_pin,
    input wire logic charging_active,
    input wire logic fault_event,
    input wire logic stat_enable,
    input wire logic pin_boost_cfg,
    input wire logic pin_boost_disable,
    input wire logic stat_oe,
    input wire logic charge_enable,
    input wire logic vbus_hiz,
    input wire logic boost_mode,
    input wire logic input_limit_500,
    input wire logic [SL_W-1:0] safety_limits,
    input wire logic safety_locked
);
    logic [2:0] up_reg;
    int pcnt_reg;
    // Pulse window mirror; faults inside it are ignored
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            up_reg <= 3'h0;
            pcnt_reg <= 0;
        end else begin
            up_reg <= (up_reg == 3'h7) ? up_reg : up_reg + 3'h1;
            if (pcnt_reg != 0)
                pcnt_reg <= (pcnt_reg == FAULT_CYC) ? 0 : pcnt_reg + 1;
            else if (fault_event)
                pcnt_reg <= 1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (up_reg != 3'h7);
    stat_off_a:
        assert property ((!stat_enable)[*2] |-> !stat_oe) else $error("status pin active while off");
    stat_charge_a:
        assert property ((stat_enable && charging_active)[*2] |-> stat_oe) else $error("status not low in charge");
    stat_release_a:
        assert property (pcnt_reg == 0 && !$past(charging_active) |-> !stat_oe) else $error("status not released");
    fault_pulse_a:
        assert property (pcnt_reg != 0 && stat_enable && $past(stat_enable) |-> stat_oe) else $error("fault pulse short");
    dis_block_a:
        assert property (vbus_hiz == $past(charge_disable_input, 3) && charge_enable != vbus_hiz)
        else $error("charge disable wrong");
    boost_force_a:
        assert property ((pin_boost_cfg && !pin_boost_disable)[*4] ##0 $past(boost_or_limit_select_pin, 3) |-> boost_mode)
        else $error("boost not forced");
    limit_sel_a:
        assert property ((!pin_boost_cfg)[*4] |-> input_limit_500 == $past(boost_or_limit_select_pin, 3))
        else $error("input limit wrong");
    slr_default_a:
        assert property ((!safety_limit_reset_pin)[*4] |-> safety_limits == CHG_SL_RESET && !safety_locked)
        else $error("limits not at default");
    lock_hold_a:
        assert property (safety_locked ##1 safety_locked |-> $stable(safety_limits)) else $error("locked limits moved");
    fault_seen_c: cover property (pcnt_reg == FAULT_CYC);
    lock_seen_c: cover property (safety_locked);
    boost_seen_c: cover property (boost_mode);
endmodule
bind chg_ctrl chg_ctrl_props #(.FAULT_CYC(FAULT_CYC), .SL_W(SL_W)) chg_ctrl_props_i (.*);
`default_nettype wire

//--- bench/chg_host_model.sv
// Purpose: Host side driving the control pins
// Assumes: Bench hands over wanted levels {disable, boost, limit reset}
// Notes: Pins move only just after a clock edge
`timescale 1ns/1ps
`default_nettype none
module chg_host_model (
    input wire logic clk,
    input wire logic [2:0] pin_req,
    output logic charge_disable_input,
    output logic boost_or_limit_select_pin,
    output logic safety_limit_reset_pin
);
    always @(posedge clk)
        {charge_disable_input, boost_or_limit_select_pin, safety_limit_reset_pin} <= pin_req;
endmodule
`default_nettype wire

//--- bench/chg_ctrl_tb.sv
// Purpose: Self-checking bench for chg_ctrl
// Assumes: Pulse 8, timers 50 and 20 cycles
// Notes: Pin waits cover host model, sync and register
`timescale 1ns/1ps
`default_nettype none
module chg_ctrl_tb;
    import chg_pkg::*;
    logic clk = 1'b0, nrst = 1'b0, charging_active = 1'b0, fault_event = 1'b0, stat_enable = 1'b0;
    logic pin_boost_cfg = 1'b0, pin_boost_disable = 1'b0, i2c_boost_req = 1'b0, timer_mode_15min = 1'b0;
    logic timer_host_reset = 1'b0, sl_write = 1'b0, other_write = 1'b0;
    logic [7:0] sl_wdata = 8'h00, d;
    logic [2:0] pin_req = 3'h0;
    wire logic charge_disable_input, boost_or_limit_select_pin, safety_limit_reset_pin, stat_out, stat_oe;
    wire logic charge_enable, vbus_hiz, boost_mode, input_limit_500, safety_locked, timer_expired;
    wire logic [7:0] safety_limits;
    int fails = 0, tests_run = 0, n, i, seed = 32'h44017fd2;
    chg_ctrl #(.FAULT_CYC(8), .T15_CYC(50), .T32_CYC(20)) chg_ctrl_i (.*);
    chg_host_model chg_host_model_i (.*);
    always #5 clk = ~clk;
    task chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task look(input int k);
        repeat (k) @(posedge clk);
        @(negedge clk);
    endtask
    // Second fault lands inside the pulse and must not stretch it
    task fault_run;
        n = 0;
        for (int k = 0; k < 20; k++) begin
            @(posedge clk) fault_event <= (k == 0 || k == 3);
            @(negedge clk) n += stat_oe;
        end
    endtask
    task give_verdict;
        if (fails == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        look(6);
        for (i = 0; i < 6; i++) begin
            d = $random(seed);
            @(posedge clk) pin_req <= {1'b0, d[0], 1'b0};
            look(5);
            chk(input_limit_500, d[0] ? CHG_LIMIT_500 : CHG_LIMIT_100);
        end
        @(posedge clk) pin_boost_cfg <= 1'b1;
        for (i = 0; i < 8; i++) begin
            @(posedge clk) {pin_boost_disable, i2c_boost_req} <= {i[2], i[1]};
            pin_req <= {1'b0, i[0], 1'b0};
            look(5);
            chk(boost_mode, i[1] | (i[0] & ~i[2]));
        end
        @(posedge clk) {pin_boost_cfg, i2c_boost_req} <= 2'b00;
        for (i = 0; i < 2; i++) begin
            @(posedge clk) pin_req <= {~i[0], 2'b00};
            look(5);
            chk(vbus_hiz, !i[0]);
            chk(charge_enable, i[0]);
        end
        @(posedge clk) {stat_enable, charging_active} <= 2'b11;
        look(2);
        chk(stat_oe, 1);
        chk(stat_out, 0);
        @(posedge clk) charging_active <= 1'b0;
        fault_run();
        chk(n, 8);
        @(posedge clk) {stat_enable, charging_active} <= 2'b01;
        fault_run();
        chk(n, 0);
        d = $random(seed) | 1;
        @(posedge clk) pin_req <= 3'h1;
        look(5);
        @(posedge clk) {sl_write, sl_wdata} <= {1'b1, d};
        @(posedge clk) {sl_write, other_write} <= 2'b01;
        @(posedge clk) {sl_write, other_write, sl_wdata} <= {2'b10, d ^ 8'h80};
        @(posedge clk) sl_write <= 1'b0;
        @(negedge clk);
        chk(safety_limits, d);
        chk(safety_locked, 1);
        @(posedge clk) pin_req <= 3'h0;
        look(5);
        chk(safety_locked, 0);
        @(posedge clk) {sl_write, sl_wdata} <= {1'b1, d};
        @(posedge clk) sl_write <= 1'b0;
        @(negedge clk);
        chk(safety_limits, CHG_SL_RESET);
        for (i = 0; i < 2; i++) begin
            @(posedge clk) {timer_mode_15min, timer_host_reset} <= {i[0], 1'b1};
            @(posedge clk) timer_host_reset <= 1'b0;
            repeat (i ? 38 : 8) @(posedge clk);
            @(posedge clk) pin_req <= 3'h4;
            repeat (3) @(posedge clk);
            @(posedge clk) pin_req <= 3'h0;
            look(i ? 25 : 16);
            chk(timer_expired, !i[0]);
        end
        look(40);
        chk(timer_expired, 1);
        give_verdict();
    end
endmodule
`default_nettype wire
